// [hdl/dual_timer.sv]
// Function
// - a running timer steps once per clock, otherwise holds its count
// - two mode bits per timer select 13-bit, 16-bit, reload or split
// - mode 0 counts high byte behind a five-bit low prescaler
// - mode 0 upper three low-byte bits carry no meaning
// - wrap from all ones to zero sets the timer overflow flag
// - a timer counts only while its run bit is one, except timer 1 while timer 0 is in mode 3
// - setting run starts counting and leaves the count bytes untouched
// - mode 1 counts all sixteen bits with no prescaler
// - mode 2 low byte counts, reloads from high byte on overflow
// - timer 1 in mode 3 stops as if its run bit were clear
// - timer 0 mode 3 low byte uses timer 0 run and flag
// - timer 0 mode 3 high byte uses timer 1 run, flag, interrupt
// - then timer 1 runs unless in mode 3, still giving baud ticks
// - timer 0 flag set on overflow, cleared by vectoring or software
// - external type bits pick falling edge or low level triggering
// - external edge flags set by hardware, cleared by service or software
// - timer 1 flag at bit 7 like timer 0; run bit 6 software only
module dual_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external interrupt pins, active low
  input wire logic [1:0] ext_irq_n,
  // processor vectoring acknowledge, one bit per event
  input wire logic [timer_pkg::NUM_EV-1:0] irq_ack,
  // interrupt and serial baud tick
  output logic irq,
  output logic baud_tick
);
  import timer_pkg::*;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] mode;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;
    logic [1:0] ext_prev;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
    logic baud;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    control: CONTROL_RESET,
    mode: MODE_RESET,
    status: STATUS_RESET,
    mask: MASK_RESET,
    ext_prev: EXT_IDLE,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0,
    irq: 1'b0,
    baud: 1'b0
  };

  regs_t state_reg;
  regs_t state_next;

  logic setup;
  logic done;
  logic wr;
  logic rd;
  logic [IDX_W-1:0] idx;
  logic hit;
  logic [31:0] rd_val;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] rd_clear;
  logic [1:0] ext_hit;
  logic t0_split;
  logic t1_parked;
  timer_mode_t t0_mode;
  timer_mode_t t1_mode;
  timer_ctl_t t0_ctl;
  timer_ctl_t t1_ctl;
  timer_sts_t t0_sts;
  timer_sts_t t1_sts;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  // pready comes up in the first access cycle, so every transfer is
  // one setup plus one access cycle; read data is caught at setup
  assign setup = psel & ~penable;
  assign done = psel & penable & state_reg.ready;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;
  assign idx = paddr[ADDR_W-1:2];

  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    case (idx)
      IDX_CONTROL: begin
        rd_val[7:0] = state_reg.control;
      end
      IDX_MODE: begin
        rd_val[7:0] = state_reg.mode;
      end
      IDX_T0_LOW: begin
        rd_val[7:0] = t0_sts.low;
      end
      IDX_T0_HIGH: begin
        rd_val[7:0] = t0_sts.high;
      end
      IDX_T1_LOW: begin
        rd_val[7:0] = t1_sts.low;
      end
      IDX_T1_HIGH: begin
        rd_val[7:0] = t1_sts.high;
      end
      IDX_IRQ_STATUS: begin
        rd_val[NUM_EV-1:0] = state_reg.status;
      end
      IDX_IRQ_MASK: begin
        rd_val[NUM_EV-1:0] = state_reg.mask;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // timer steering
  // ------------------------------------------------------------
  assign t0_mode = timer_mode_t'(state_reg.mode[MODE_T0_LSB +: 2]);
  assign t1_mode = timer_mode_t'(state_reg.mode[MODE_T1_LSB +: 2]);
  assign t0_split = t0_mode == MODE_SPLIT;
  assign t1_parked = t1_mode == MODE_SPLIT;

  always_comb begin
    t0_ctl.mode = t0_mode;
    t0_ctl.run_main = state_reg.control[CTL_T0_RUN];
    t0_ctl.run_high = state_reg.control[CTL_T1_RUN];
    t0_ctl.ld_low = wr && idx == IDX_T0_LOW;
    t0_ctl.ld_high = wr && idx == IDX_T0_HIGH;
    t0_ctl.wbyte = pwdata[7:0];
    t1_ctl.mode = t1_mode;
    // with timer 0 split, timer 1 is switched only by its own mode
    if (t0_split) begin
      t1_ctl.run_main = ~t1_parked;
    end else begin
      t1_ctl.run_main = state_reg.control[CTL_T1_RUN] & ~t1_parked;
    end
    t1_ctl.run_high = 1'b0;
    t1_ctl.ld_low = wr && idx == IDX_T1_LOW;
    t1_ctl.ld_high = wr && idx == IDX_T1_HIGH;
    t1_ctl.wbyte = pwdata[7:0];
  end

  timer_slice u_timer0 (
    .pclk(pclk),
    .presetn(presetn),
    .ctl(t0_ctl),
    .sts(t0_sts)
  );

  timer_slice u_timer1 (
    .pclk(pclk),
    .presetn(presetn),
    .ctl(t1_ctl),
    .sts(t1_sts)
  );

  // ------------------------------------------------------------
  // events
  // ------------------------------------------------------------
  // type bit one: falling edge; zero: low level sets the flag each cycle
  assign ext_hit[0] = state_reg.control[CTL_EXT0_TYPE] ?
    (state_reg.ext_prev[0] & ~ext_irq_n[0]) : ~ext_irq_n[0];
  assign ext_hit[1] = state_reg.control[CTL_EXT1_TYPE] ?
    (state_reg.ext_prev[1] & ~ext_irq_n[1]) : ~ext_irq_n[1];

  always_comb begin
    ev = '0;
    ev[EV_T0] = t0_sts.ovf_main;
    // timer 1 overflow loses its flag while timer 0 is split
    ev[EV_T1] = t0_split ? t0_sts.ovf_high : t1_sts.ovf_main;
    ev[EV_EXT0] = ext_hit[0];
    ev[EV_EXT1] = ext_hit[1];
  end

  // only bits actually returned by the read are cleared
  assign rd_clear = (rd && idx == IDX_IRQ_STATUS) ? state_reg.rdata[NUM_EV-1:0] : '0;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.ext_prev = ext_irq_n;
    // vectoring clears the hardware flags
    if (irq_ack[EV_T0]) begin
      state_next.control[CTL_T0_OVF] = 1'b0;
    end
    if (irq_ack[EV_T1]) begin
      state_next.control[CTL_T1_OVF] = 1'b0;
    end
    if (irq_ack[EV_EXT0]) begin
      state_next.control[CTL_EXT0_EDGE] = 1'b0;
    end
    if (irq_ack[EV_EXT1]) begin
      state_next.control[CTL_EXT1_EDGE] = 1'b0;
    end
    // writes land at the access edge; counts sit in the slices untouched
    if (wr && idx == IDX_CONTROL) begin
      state_next.control = pwdata[7:0];
    end
    if (wr && idx == IDX_MODE) begin
      state_next.mode = pwdata[7:0] & MODE_WMASK;
    end
    if (wr && idx == IDX_IRQ_MASK) begin
      state_next.mask = pwdata[NUM_EV-1:0];
    end
    // sets are applied last so they beat any clear
    state_next.control[CTL_T0_OVF] = state_next.control[CTL_T0_OVF] | ev[EV_T0];
    state_next.control[CTL_T1_OVF] = state_next.control[CTL_T1_OVF] | ev[EV_T1];
    state_next.control[CTL_EXT0_EDGE] = state_next.control[CTL_EXT0_EDGE] | ev[EV_EXT0];
    state_next.control[CTL_EXT1_EDGE] = state_next.control[CTL_EXT1_EDGE] | ev[EV_EXT1];
    state_next.status = (state_reg.status & ~rd_clear) | ev;
    state_next.ready = setup;
    state_next.slverr = setup & ~hit;
    if (setup) begin
      state_next.rdata = rd_val;
    end
    state_next.irq = |(state_next.status & state_next.mask);
    state_next.baud = t1_sts.ovf_main;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= REGS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.slverr;
  assign irq = state_reg.irq;
  assign baud_tick = state_reg.baud;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_ready;
    s_setup ##1 (psel && penable) |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access cycle");

  property p_t0_flag;
    t0_sts.ovf_main |=> state_reg.control[CTL_T0_OVF] && state_reg.status[EV_T0];
  endproperty
  a_t0_flag: assert property (p_t0_flag) else $error("timer 0 flag not set");

  property p_set_wins;
    (ext_hit[0] && wr && idx == IDX_CONTROL && !pwdata[CTL_EXT0_EDGE])
      |=> state_reg.control[CTL_EXT0_EDGE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat the set");

  property p_split;
    (t0_split && t0_sts.ovf_high) |=> state_reg.control[CTL_T1_OVF] && state_reg.status[EV_T1];
  endproperty
  a_split: assert property (p_split) else $error("split high overflow lost");

  property p_t1_stop;
    (t1_parked && !t1_ctl.ld_low && !t1_ctl.ld_high)
      |=> $stable(t1_sts.low) && $stable(t1_sts.high);
  endproperty
  a_t1_stop: assert property (p_t1_stop) else $error("timer 1 ran in mode 3");

  property p_edge;
    (state_reg.control[CTL_EXT0_TYPE] && state_reg.ext_prev[0] && !ext_irq_n[0])
      |=> state_reg.control[CTL_EXT0_EDGE] && state_reg.status[EV_EXT0];
  endproperty
  a_edge: assert property (p_edge) else $error("falling edge missed");

  property p_irq;
    (|(state_reg.status & state_reg.mask)) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_rdclr;
    (s_access and (!pwrite && idx == IDX_IRQ_STATUS && state_reg.rdata[EV_T0] && !ev[EV_T0]))
      |=> !state_reg.status[EV_T0];
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("status not cleared by read");

  property p_slverr;
    s_setup ##1 (psel && penable) |-> (pslverr == !hit);
  endproperty
  a_slverr: assert property (p_slverr) else $error("error flag wrong for index");

  property p_rdata;
    s_setup |=> (prdata == $past(rd_val));
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not caught at setup");

  property p_mode_wr;
    (wr && idx == IDX_MODE) |=> (state_reg.mode == ($past(pwdata[7:0]) & MODE_WMASK));
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write did not land");

  property p_ack_clr;
    (irq_ack[EV_T0] && !ev[EV_T0] && !(wr && idx == IDX_CONTROL))
      |=> !state_reg.control[CTL_T0_OVF];
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("ack left timer 0 flag");

  property p_level;
    (!state_reg.control[CTL_EXT1_TYPE] && !ext_irq_n[1])
      |=> state_reg.control[CTL_EXT1_EDGE] && state_reg.status[EV_EXT1];
  endproperty
  a_level: assert property (p_level) else $error("low level did not set flag");

  property p_baud;
    t1_sts.ovf_main |=> baud_tick;
  endproperty
  a_baud: assert property (p_baud) else $error("baud tick missing");

  property p_t1_free;
    (t0_split && t1_mode == MODE_16BIT && !t1_ctl.ld_low && !t1_ctl.ld_high)
      |=> {t1_sts.high, t1_sts.low} == $past({t1_sts.high, t1_sts.low}) + 16'h0001;
  endproperty
  a_t1_free: assert property (p_t1_free) else $error("timer 1 held while split");
endmodule

// [hdl/timer_pkg.sv]
package timer_pkg;
  // ------------------------------------------------------------
  // bus geometry; byte address is four times the index
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [9:0] IDX_CONTROL = 10'h088;
  localparam logic [9:0] IDX_MODE = 10'h089;
  localparam logic [9:0] IDX_T0_LOW = 10'h08A;
  localparam logic [9:0] IDX_T0_HIGH = 10'h08B;
  localparam logic [9:0] IDX_T1_LOW = 10'h08C;
  localparam logic [9:0] IDX_T1_HIGH = 10'h08D;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h090;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h091;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL_EXT0_TYPE = 0;
  localparam int CTL_EXT0_EDGE = 1;
  localparam int CTL_EXT1_TYPE = 2;
  localparam int CTL_EXT1_EDGE = 3;
  localparam int CTL_T0_RUN = 4;
  localparam int CTL_T0_OVF = 5;
  localparam int CTL_T1_RUN = 6;
  localparam int CTL_T1_OVF = 7;
  localparam int MODE_T0_LSB = 0;
  localparam int MODE_T1_LSB = 4;
  localparam int EV_T0 = 0;
  localparam int EV_T1 = 1;
  localparam int EV_EXT0 = 2;
  localparam int EV_EXT1 = 3;
  localparam int NUM_EV = 4;
  localparam int PRESCALE_BITS = 5;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h33;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [1:0] EXT_IDLE = 2'h3;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_t;

  typedef struct packed {
    timer_mode_t mode;
    logic run_main;
    logic run_high;
    logic ld_low;
    logic ld_high;
    logic [7:0] wbyte;
  } timer_ctl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic ovf_main;
    logic ovf_high;
  } timer_sts_t;
endpackage

// [hdl/timer_slice.sv]
module timer_slice (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the register file
  input wire timer_pkg::timer_ctl_t ctl,
  // count bytes and overflow strobes
  output timer_pkg::timer_sts_t sts
);
  import timer_pkg::*;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } slice_t;

  slice_t cnt_reg;
  slice_t cnt_next;
  logic low5_full;
  logic low_full;
  logic high_full;
  logic ovf_main;
  logic ovf_high;

  // ------------------------------------------------------------
  // count logic
  // ------------------------------------------------------------
  always_comb begin
    low5_full = &cnt_reg.low[PRESCALE_BITS-1:0];
    low_full = &cnt_reg.low;
    high_full = &cnt_reg.high;
    ovf_main = 1'b0;
    ovf_high = 1'b0;
    cnt_next = cnt_reg;
    if (ctl.run_main) begin
      case (ctl.mode)
        MODE_13BIT: begin
          // upper three low bits are left alone; their value is meaningless
          cnt_next.low[PRESCALE_BITS-1:0] = cnt_reg.low[PRESCALE_BITS-1:0] + 5'h01;
          if (low5_full) begin
            cnt_next.high = cnt_reg.high + 8'h01;
            ovf_main = high_full;
          end
        end
        MODE_16BIT: begin
          {cnt_next.high, cnt_next.low} = {cnt_reg.high, cnt_reg.low} + 16'h0001;
          ovf_main = high_full & low_full;
        end
        MODE_RELOAD: begin
          cnt_next.low = low_full ? cnt_reg.high : cnt_reg.low + 8'h01;
          ovf_main = low_full;
        end
        default: begin
          cnt_next.low = cnt_reg.low + 8'h01;
          ovf_main = low_full;
        end
      endcase
    end
    if (ctl.run_high && ctl.mode == MODE_SPLIT) begin
      cnt_next.high = cnt_reg.high + 8'h01;
      ovf_high = high_full;
    end
    // software load wins over counting in the same cycle
    if (ctl.ld_low) begin
      cnt_next.low = ctl.wbyte;
    end
    if (ctl.ld_high) begin
      cnt_next.high = ctl.wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '{high: COUNT_RESET, low: COUNT_RESET};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign sts = '{high: cnt_reg.high, low: cnt_reg.low, ovf_main: ovf_main, ovf_high: ovf_high};

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_hold;
    (!ctl.run_main && !ctl.run_high && !ctl.ld_low && !ctl.ld_high) |=> $stable(cnt_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while stopped");

  property p_inc16;
    (ctl.run_main && ctl.mode == MODE_16BIT && !ctl.ld_low && !ctl.ld_high)
      |=> {cnt_reg.high, cnt_reg.low} == $past({cnt_reg.high, cnt_reg.low}) + 16'h0001;
  endproperty
  a_inc16: assert property (p_inc16) else $error("16-bit count did not step");

  property p_reload;
    (ctl.run_main && ctl.mode == MODE_RELOAD && low_full && !ctl.ld_low && !ctl.ld_high)
      |=> cnt_reg.low == $past(cnt_reg.high) && $stable(cnt_reg.high);
  endproperty
  a_reload: assert property (p_reload) else $error("reload failed");

  property p_mode0;
    (ctl.run_main && ctl.mode == MODE_13BIT && !ctl.ld_low && !ctl.ld_high && !low5_full)
      |=> $stable(cnt_reg.high) && $stable(cnt_reg.low[7:PRESCALE_BITS]);
  endproperty
  a_mode0: assert property (p_mode0) else $error("prescaler carry wrong");
endmodule

// [verification/dual_timer_counter_four_modes_bench.sv]
module dual_timer_counter_four_modes_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] ext_irq_n;
  logic [NUM_EV-1:0] irq_ack;
  logic irq;
  logic baud_tick;
  logic slverr;
  logic [31:0] rdv;
  int mismatches;
  int n_checks;

  dual_timer dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ext_irq_n(ext_irq_n),
    .irq_ack(irq_ack),
    .irq(irq),
    .baud_tick(baud_tick)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ------------------------------------------------------------
  // apb master; read data and pslverr are taken at the pready edge
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
    rdv = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h000000, d});
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] exp,
                    input string name);
    apb(1'b0, idx, 32'h00000000);
    check(name, rdv & {24'hFFFFFF, m}, {24'h000000, exp});
  endtask

  task automatic ack(input logic [NUM_EV-1:0] v);
    @(posedge pclk);
    irq_ack <= v;
    @(posedge pclk);
    irq_ack <= '0;
  endtask

  // two writes back to back land three edges apart: exactly three steps
  task automatic pulse_run(input logic [7:0] run);
    wr(IDX_CONTROL, run);
    wr(IDX_CONTROL, 8'h00);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ext_irq_n = EXT_IDLE;
    irq_ack = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;

    rd(IDX_CONTROL, 8'hFF, 8'h00, "control reset");
    rd(IDX_MODE, 8'hFF, 8'h00, "mode reset");
    rd(IDX_IRQ_MASK, 8'hFF, 8'h00, "mask reset");
    wr(IDX_MODE, 8'hFF);
    rd(IDX_MODE, 8'hFF, 8'h33, "mode writable bits");
    wr(10'h0FF, 8'h5A);
    check("unmapped write error", {31'h0, slverr}, 32'h1);
    apb(1'b0, 10'h0FF, 32'h0);
    check("unmapped read error", {31'h0, slverr}, 32'h1);
    check("unmapped read data", rdv, 32'h0);

    // 16-bit wrap; mask is clear so irq must stay low
    wr(IDX_T0_LOW, 8'hFE);
    wr(IDX_T0_HIGH, 8'hFF);
    wr(IDX_MODE, 8'h01);
    pulse_run(8'h10);
    rd(IDX_T0_LOW, 8'hFF, 8'h01, "mode1 low");
    rd(IDX_T0_HIGH, 8'hFF, 8'h00, "mode1 high");
    rd(IDX_T0_LOW, 8'hFF, 8'h01, "stopped low holds");
    check("irq masked", {31'h0, irq}, 32'h0);
    rd(IDX_IRQ_STATUS, 8'hFF, 8'h01, "mode1 overflow");
    rd(IDX_IRQ_STATUS, 8'hFF, 8'h00, "status read clears");

    // 13-bit: carry out of the five-bit prescaler; top three bits ignored
    wr(IDX_MODE, 8'h00);
    wr(IDX_T0_LOW, 8'h1E);
    wr(IDX_T0_HIGH, 8'h12);
    pulse_run(8'h10);
    rd(IDX_T0_LOW, 8'h1F, 8'h01, "mode0 prescaler");
    rd(IDX_T0_HIGH, 8'hFF, 8'h13, "mode0 high");

    // auto-reload
    wr(IDX_MODE, 8'h02);
    wr(IDX_T0_LOW, 8'hFE);
    wr(IDX_T0_HIGH, 8'h80);
    pulse_run(8'h10);
    rd(IDX_T0_LOW, 8'hFF, 8'h81, "mode2 reload");
    rd(IDX_T0_HIGH, 8'hFF, 8'h80, "mode2 high kept");
    rd(IDX_IRQ_STATUS, 8'hFF, 8'h01, "mode2 overflow");

    // split timer 0 with timer 1 parked in its own mode 3
    wr(IDX_IRQ_MASK, 8'h02);
    wr(IDX_MODE, 8'h33);
    wr(IDX_T0_LOW, 8'h10);
    wr(IDX_T0_HIGH, 8'hFE);
    wr(IDX_T1_LOW, 8'h05);
    pulse_run(8'h40);
    rd(IDX_T0_HIGH, 8'hFF, 8'h01, "split high byte");
    rd(IDX_T0_LOW, 8'hFF, 8'h10, "split low byte idle");
    rd(IDX_T1_LOW, 8'hFF, 8'h05, "timer1 mode3 stopped");
    check("irq from split high", {31'h0, irq}, 32'h1);
    rd(IDX_IRQ_STATUS, 8'hFF, 8'h02, "split overflow");
    repeat (2) @(posedge pclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    pulse_run(8'h10);
    rd(IDX_T0_LOW, 8'hFF, 8'h13, "split low byte");

    // timer 1 as a baud source while timer 0 is split
    wr(IDX_T1_LOW, 8'hFE);
    wr(IDX_T1_HIGH, 8'hFF);
    wr(IDX_MODE, 8'h13);
    begin
      int n;
      n = 0;
      while (baud_tick !== 1'b1 && n < 10) begin
        @(posedge pclk);
        n++;
      end
      check("baud tick seen", {31'h0, baud_tick}, 32'h1);
    end
    wr(IDX_MODE, 8'h33);
    rd(IDX_IRQ_STATUS, 8'hFF, 8'h00, "baud overflow no flag");

    // overflow flags and their acknowledge clear
    wr(IDX_MODE, 8'h11);
    for (int i = 0; i < 2; i++) begin
      wr(IDX_T0_LOW + 10'(2 * i), 8'hFF);
      wr(IDX_T0_HIGH + 10'(2 * i), 8'hFF);
      wr(IDX_CONTROL, 8'(8'h10 << (2 * i)));
      rd(IDX_CONTROL, 8'hFF, 8'(8'h30 << (2 * i)), "overflow flag");
      ack(4'(1 << i));
      rd(IDX_CONTROL, 8'hFF, 8'(8'h10 << (2 * i)), "flag acked");
      wr(IDX_CONTROL, 8'h00);
    end
    rd(IDX_IRQ_STATUS, 8'hFF, 8'h03, "both overflows");

    // external pins: falling edge then low level
    for (int ch = 0; ch < 2; ch++) begin
      wr(IDX_CONTROL, 8'(1 << (2 * ch)));
      @(posedge pclk);
      ext_irq_n[ch] <= 1'b0;
      repeat (3) @(posedge pclk);
      rd(IDX_CONTROL, 8'hFF, 8'(3 << (2 * ch)), "edge flag");
      ack(4'(4 << ch));
      rd(IDX_CONTROL, 8'hFF, 8'(1 << (2 * ch)), "edge flag acked");
      wr(IDX_CONTROL, 8'h00);
      rd(IDX_CONTROL, 8'hFF, 8'(2 << (2 * ch)), "level keeps setting");
      @(posedge pclk);
      ext_irq_n[ch] <= 1'b1;
      repeat (2) @(posedge pclk);
      wr(IDX_CONTROL, 8'h00);
      rd(IDX_CONTROL, 8'hFF, 8'h00, "software clear");
      rd(IDX_IRQ_STATUS, 8'hFF, 8'(4 << ch), "external status");
    end
    summarize();
  end
endmodule
